// ===== hw/irl_link.sv
// Infrared obstacle sensing, packet send/receive and sensor supply gating
`timescale 1ns/100ps
`default_nettype none
`include "irl_params.svh"

module irl_link
    import irl_pkg::*;
#(
    parameter int PKT_CYC   = `IRL_PKT_CYC,
    parameter int GAP_CYC   = `IRL_GAP_CYC,
    parameter int PULSE_CYC = `IRL_PULSE_CYC,
    parameter int BURST_CYC = `IRL_BURST_CYC,
    parameter int START_CYC = `IRL_START_CYC,
    parameter int FLASH_CYC = `IRL_FLASH_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire irl_power_t  emitterPower,
    input  wire logic        sensorSupplyOnReq,
    input  wire logic        sensorSupplyOffReq,
    input  wire logic        sendReq,
    input  wire logic [7:0]  sendAddress,
    input  wire logic [5:0]  sendData,
    input  wire logic        irReceiveIn,
    input  wire logic        motorRunReq,
    output logic             sendBusy,
    output logic             irPacketOut,
    output logic             emitterLeft,
    output logic             emitterRight,
    output logic [1:0]       emitterLevel,
    output logic             obstacleLeft,
    output logic             obstacleRight,
    output logic             obstacleChange,
    output logic             rxValid,
    output irl_packet_t      rxPacket,
    output logic             sensorSupply,
    output logic             motorEnable,
    output logic [3:0]       redLeds
);
    localparam int HALF_CYC = `IRL_HALFBIT_CYC;
    localparam int CAR_CYC  = `IRL_CARRIER_CYC;
    localparam int NBITS    = `IRL_NBITS;
    localparam int ECHO_CYC = 3 * BURST_CYC;

    irl_state_t st_r;
    irl_state_t st_nxt;
    logic       supply_r;
    logic       rxLevel;
    logic       rxStable;
    logic       carrierOn;
    logic       txLevel;
    logic       emitting;
    logic       echoWin;

    // ****************************************
    // Receiver input conditioning, carrier phase, transmit level and echo window
    // ****************************************
    assign rxLevel   = ~st_r.rxSync[2];
    assign rxStable  = st_r.rxSync[1] == st_r.rxSync[2];
    assign carrierOn = st_r.carrier < 32'(CAR_CYC / 2);
    assign txLevel   = st_r.shift[NBITS - 1] ^ ~st_r.halfSel;
    assign emitting  = supply_r && emitterPower != PWR_OFF;
    assign echoWin   = emitting && st_r.timer < 32'(ECHO_CYC);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rxSync = {st_r.rxSync[1:0], irReceiveIn};
        st_nxt.obstacleChange = 1'b0;
        st_nxt.rxValid = 1'b0;
        st_nxt.carrier = (st_r.carrier + 32'd1 >= 32'(CAR_CYC)) ? 32'd0 : st_r.carrier + 32'd1;
        st_nxt.timer = st_r.timer + 32'd1;
        if (rxStable) begin
            st_nxt.rxPrev = rxLevel;
        end
        if (sendReq && !st_r.txBusy) begin
            st_nxt.txBusy = 1'b1;
            st_nxt.txPacket.toggle  = sendAddress[`IRL_TOGGLE_POS];
            st_nxt.txPacket.address = sendAddress[4:0];
            st_nxt.txPacket.keyCode = sendData;
        end
        unique case (st_r.sched)
            S_SENSE: begin
                if (rxStable && rxLevel && !echoWin) begin
                    st_nxt.sched  = S_RX;
                    st_nxt.timer  = 32'd0;
                    st_nxt.bitIdx = 4'd0;
                    st_nxt.shift  = 14'h0000;
                end else if (st_r.txBusy) begin
                    st_nxt.sched   = S_TX;
                    st_nxt.timer   = 32'd0;
                    st_nxt.carrier = 32'd0;
                    st_nxt.bitIdx  = 4'd0;
                    st_nxt.halfSel = 1'b0;
                    st_nxt.shift   = {2'h3, st_r.txPacket.toggle, st_r.txPacket.address,
                                      st_r.txPacket.keyCode};
                end else if (st_r.timer + 32'd1 >= 32'(PULSE_CYC)) begin
                    st_nxt.timer = 32'd0;
                    st_nxt.carrier = 32'd0;
                    st_nxt.sideRight = ~st_r.sideRight;
                    if (st_r.sideRight) begin
                        st_nxt.hitR = st_r.sawEcho ? ((st_r.hitR == 2'h3) ? 2'h3 : st_r.hitR + 2'h1) : 2'h0;
                        st_nxt.obstacleRight = st_r.sawEcho && (st_r.hitR >= 2'(`IRL_HITS_NEED - 1));
                    end else begin
                        st_nxt.hitL = st_r.sawEcho ? ((st_r.hitL == 2'h3) ? 2'h3 : st_r.hitL + 2'h1) : 2'h0;
                        st_nxt.obstacleLeft = st_r.sawEcho && (st_r.hitL >= 2'(`IRL_HITS_NEED - 1));
                    end
                    st_nxt.sawEcho = 1'b0;
                end else if (echoWin && rxStable && rxLevel) begin
                    st_nxt.sawEcho = 1'b1;
                end
            end
            S_RX: begin
                // Sample at three quarters of each bit, mid second half
                if (rxStable && rxLevel != st_r.rxPrev && st_r.timer > 32'(HALF_CYC + HALF_CYC / 2)) begin
                    st_nxt.timer = 32'd0;
                end
                if (st_r.timer == 32'(HALF_CYC / 2)) begin
                    st_nxt.shift  = {st_r.shift[12:0], rxLevel};
                    st_nxt.bitIdx = st_r.bitIdx + 4'd1;
                end
                if (st_r.timer > 32'(4 * HALF_CYC)) begin
                    st_nxt.sched = S_GAP;
                    st_nxt.timer = 32'd0;
                end else if (st_r.bitIdx == 4'(NBITS)) begin
                    st_nxt.sched = S_GAP;
                    st_nxt.timer = 32'd0;
                    if (st_r.shift[13:12] == 2'h3) begin
                        st_nxt.rxValid  = 1'b1;
                        st_nxt.rxPacket.toggle  = st_r.shift[11];
                        st_nxt.rxPacket.address = st_r.shift[10:6];
                        st_nxt.rxPacket.keyCode = st_r.shift[5:0];
                    end
                end
            end
            S_TX: begin
                if (st_r.timer + 32'd1 >= 32'(HALF_CYC)) begin
                    st_nxt.timer = 32'd0;
                    st_nxt.halfSel = ~st_r.halfSel;
                    if (st_r.halfSel) begin
                        st_nxt.shift  = {st_r.shift[12:0], 1'b0};
                        st_nxt.bitIdx = st_r.bitIdx + 4'd1;
                        if (st_r.bitIdx == 4'(NBITS - 1)) begin
                            st_nxt.sched = S_GAP;
                            st_nxt.txBusy = 1'b0;
                        end
                    end
                end
            end
            S_GAP: begin
                if (st_r.timer + 32'd1 >= 32'(GAP_CYC + PKT_CYC - NBITS * 2 * HALF_CYC)) begin
                    st_nxt.sched = S_SENSE;
                    st_nxt.timer = 32'd0;
                    st_nxt.carrier = 32'd0;
                end
            end
            default: begin
                st_nxt.sched = S_SENSE;
            end
        endcase
        if (st_nxt.obstacleLeft != st_r.obstacleLeft || st_nxt.obstacleRight != st_r.obstacleRight) begin
            st_nxt.obstacleChange = 1'b1;
        end
        // Motor guard when supply is off
        if (!motorRunReq) begin
            st_nxt.motorTimer = 32'd0;
            st_nxt.motorStop  = 1'b0;
        end else if (!supply_r && !st_r.motorStop) begin
            st_nxt.motorTimer = st_r.motorTimer + 32'd1;
            if (st_r.motorTimer + 32'd1 >= 32'(START_CYC)) begin
                st_nxt.motorStop = 1'b1;
            end
        end
        if (st_r.motorStop) begin
            st_nxt.flashTimer = st_r.flashTimer + 32'd1;
            if (st_r.flashTimer + 32'd1 >= 32'(FLASH_CYC)) begin
                st_nxt.flashTimer = 32'd0;
                st_nxt.flash = ~st_r.flash;
            end
        end else begin
            st_nxt.flash = 1'b0;
            st_nxt.flashTimer = 32'd0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.sched <= S_SENSE;
            st_r.rxSync <= 3'h7;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            supply_r <= 1'b0;
        end else if (sensorSupplyOnReq) begin
            supply_r <= 1'b1;
        end else if (sensorSupplyOffReq) begin
            supply_r <= 1'b0;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sendBusy       = st_r.txBusy;
    assign irPacketOut    = st_r.sched == S_TX && txLevel && carrierOn;
    assign emitterLeft    = st_r.sched == S_SENSE && supply_r && emitterPower != PWR_OFF
                            && !st_r.sideRight && st_r.timer < 32'(BURST_CYC) && carrierOn;
    assign emitterRight   = st_r.sched == S_SENSE && supply_r && emitterPower != PWR_OFF
                            && st_r.sideRight && st_r.timer < 32'(BURST_CYC) && carrierOn;
    assign emitterLevel   = emitterPower;
    assign obstacleLeft   = st_r.obstacleLeft;
    assign obstacleRight  = st_r.obstacleRight;
    assign obstacleChange = st_r.obstacleChange;
    assign rxValid        = st_r.rxValid;
    assign rxPacket       = st_r.rxPacket;
    assign sensorSupply   = supply_r;
    assign motorEnable    = motorRunReq && !st_r.motorStop;
    assign redLeds        = {4{st_r.flash}};
endmodule
`default_nettype wire

// ===== hw/irl_params.svh
// Timing and field constants of the infrared obstacle and packet link
`ifndef IRL_PARAMS_SVH
`define IRL_PARAMS_SVH
`define IRL_CLK_HZ          40000000
`define IRL_HALFBIT_NS      889
`define IRL_HALFBIT_CYC     ((`IRL_HALFBIT_NS * 40) / 1000)
`define IRL_CARRIER_HZ      36000
`define IRL_CARRIER_CYC     (`IRL_CLK_HZ / `IRL_CARRIER_HZ)
`define IRL_PKT_MS          20
`define IRL_PKT_CYC         (`IRL_PKT_MS * (`IRL_CLK_HZ / 1000))
`define IRL_GAP_MS          5
`define IRL_GAP_CYC         (`IRL_GAP_MS * (`IRL_CLK_HZ / 1000))
`define IRL_PULSE_US        1000
`define IRL_PULSE_CYC       (`IRL_PULSE_US * (`IRL_CLK_HZ / 1000000))
`define IRL_BURST_US        200
`define IRL_BURST_CYC       (`IRL_BURST_US * (`IRL_CLK_HZ / 1000000))
`define IRL_START_MS        300
`define IRL_START_CYC       (`IRL_START_MS * (`IRL_CLK_HZ / 1000))
`define IRL_FLASH_MS        250
`define IRL_FLASH_CYC       (`IRL_FLASH_MS * (`IRL_CLK_HZ / 1000))
`define IRL_NBITS           14
`define IRL_TOGGLE_POS      7
`define IRL_HITS_NEED       3
`endif

// ===== hw/irl_pkg.sv
// Types of the infrared obstacle and packet link
package irl_pkg;
    typedef enum logic [1:0] {
        PWR_OFF = 2'h0,
        PWR_SHORT = 2'h1,
        PWR_MEDIUM = 2'h2,
        PWR_LONG = 2'h3
    } irl_power_t;

    typedef enum logic [3:0] {
        S_SENSE = 4'h1,
        S_RX    = 4'h2,
        S_TX    = 4'h4,
        S_GAP   = 4'h8
    } irl_sched_t;

    typedef struct packed {
        logic [4:0] address;
        logic       toggle;
        logic [5:0] keyCode;
    } irl_packet_t;

    typedef struct packed {
        irl_sched_t  sched;
        logic [31:0] timer;
        logic [31:0] carrier;
        logic [3:0]  bitIdx;
        logic        halfSel;
        logic [13:0] shift;
        logic        sideRight;
        logic [1:0]  hitL;
        logic [1:0]  hitR;
        logic        sawEcho;
        logic        obstacleLeft;
        logic        obstacleRight;
        logic        obstacleChange;
        logic        rxValid;
        irl_packet_t rxPacket;
        logic        txBusy;
        irl_packet_t txPacket;
        logic [2:0]  rxSync;
        logic        rxPrev;
        logic        motorStop;
        logic [31:0] motorTimer;
        logic [31:0] flashTimer;
        logic        flash;
    } irl_state_t;
endpackage

// ===== test/irl_link_assertions.sv
// Concurrent checks on the infrared link ports
`timescale 1ns/100ps
`default_nettype none
module irl_link_assertions
    import irl_pkg::*;
#(
    parameter int START_CYC = 100
) (
    input wire logic       clk,
    input wire logic       rstn,
    input wire irl_power_t emitterPower,
    input wire logic       sensorSupplyOnReq,
    input wire logic       sendReq,
    input wire logic       motorRunReq,
    input wire logic       sendBusy,
    input wire logic       irPacketOut,
    input wire logic       emitterLeft,
    input wire logic       emitterRight,
    input wire logic       obstacleLeft,
    input wire logic       obstacleRight,
    input wire logic       obstacleChange,
    input wire logic       rxValid,
    input wire logic       sensorSupply,
    input wire logic       motorEnable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    int busyCnt;
    int onCnt;
    int runCnt;
    // Run lengths
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busyCnt <= 0;
            onCnt <= 0;
            runCnt <= 0;
        end else begin
            busyCnt <= sendBusy ? busyCnt + 1 : 0;
            onCnt <= irPacketOut ? onCnt + 1 : 0;
            runCnt <= (motorEnable && !sensorSupply) ? runCnt + 1 : 0;
        end
    end
    a_send_taken: assert property (sendReq && !sendBusy |=> sendBusy)
        else $error("Send request not taken");
    a_packet_length: assert property ($fell(sendBusy) |-> busyCnt >= 980)
        else $error("Packet shorter than 28 half bits");
    a_pause_after: assert property ($fell(sendBusy) |-> (!emitterLeft && !emitterRight)[*8])
        else $error("No pause after packet");
    a_path_shared: assert property (irPacketOut |-> !emitterLeft && !emitterRight)
        else $error("Send overlaps sensing");
    a_pulsed_only: assert property (onCnt < 600)
        else $error("Transmit output held on");
    a_dark_off: assert property (emitterPower == PWR_OFF |-> !emitterLeft && !emitterRight)
        else $error("Emitters lit at power off");
    a_change_event: assert property ((obstacleLeft != $past(obstacleLeft))
        || (obstacleRight != $past(obstacleRight)) |-> ##[0:1] obstacleChange)
        else $error("Flag change without event");
    a_rx_single: assert property (rxValid |=> !rxValid)
        else $error("Receive event not single");
    a_supply_pin: assert property (sensorSupplyOnReq |=> sensorSupply)
        else $error("Supply request ignored");
    a_motor_guard: assert property (runCnt <= START_CYC + 2)
        else $error("Unpowered motor not stopped");
    a_motor_gate: assert property (motorEnable |-> motorRunReq)
        else $error("Motor on without request");
    cover property ($rose(obstacleLeft && obstacleRight));
    cover property (rxValid);
    cover property ($fell(sendBusy));
endmodule
`default_nettype wire

// ===== test/irl_remote_model.sv
// Far-side IR partner: remote packets and obstacle reflections
`timescale 1ns/100ps
`default_nettype none
`include "irl_params.svh"
module irl_remote_model (
    input  wire logic clk,
    input  wire logic emitterLeft,
    input  wire logic emitterRight,
    input  wire logic reflectLeft,
    input  wire logic reflectRight,
    output logic      irReceiveIn
);
    logic [7:0] echoCnt = 8'h00;
    logic       markOn  = 1'b0;
    // Receiver output stretched over a reflected burst
    always @(posedge clk) begin
        if ((emitterLeft && reflectLeft) || (emitterRight && reflectRight)) begin
            echoCnt <= 8'h46;
        end else if (echoCnt != 8'h00) begin
            echoCnt <= echoCnt - 8'h01;
        end
    end
    assign irReceiveIn = !(markOn || (echoCnt != 8'h00));
    // Manchester, MSB first, one is space then mark
    task automatic sendBits(input logic [13:0] bits);
        for (int i = 13; i >= 0; i--) begin
            markOn = !bits[i];
            repeat (`IRL_HALFBIT_CYC) @(negedge clk);
            markOn = bits[i];
            repeat (`IRL_HALFBIT_CYC) @(negedge clk);
        end
        markOn = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== test/ir_obstacle_and_rc5_link_test.sv
// Self-checking bench of the infrared link
`timescale 1ns/100ps
`default_nettype none
module ir_obstacle_and_rc5_link_test
    import irl_pkg::*;
;
    localparam int START_CYC = 100;
    localparam int FLASH_CYC = 50;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    irl_power_t  emitterPower = PWR_OFF;
    logic        sensorSupplyOnReq = 1'b0, sensorSupplyOffReq = 1'b0, sendReq = 1'b0;
    logic        motorRunReq = 1'b0, reflectLeft = 1'b0, reflectRight = 1'b0;
    logic [7:0]  sendAddress = 8'h00;
    logic [5:0]  sendData = 6'h00;
    logic        irReceiveIn, sendBusy, irPacketOut, emitterLeft, emitterRight;
    logic        obstacleLeft, obstacleRight, obstacleChange, rxValid, sensorSupply;
    logic        motorEnable, sawOn, sawOff;
    logic [1:0]  emitterLevel;
    logic [3:0]  redLeds;
    irl_packet_t rxPacket, pkt;
    irl_packet_t expQ[$];
    logic [31:0] rnd = 32'hD71F2DEA;
    int          badCount = 0, checked = 0, chgCount = 0, rxCount = 0, n;
    irl_link #(.PKT_CYC(2000), .GAP_CYC(500), .PULSE_CYC(200), .BURST_CYC(60),
        .START_CYC(START_CYC), .FLASH_CYC(FLASH_CYC)) DUT (.*);
    irl_remote_model partner (.*);
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic waitFlags(input logic [1:0] want);
        for (n = 0; n < 3000 && {obstacleLeft, obstacleRight} !== want; n++) @(negedge clk);
        repeat (3) @(negedge clk);
        check("obstacleFlags", {obstacleLeft, obstacleRight}, want);
    endtask
    // Receive events against the oldest expected packet
    always @(negedge clk) begin
        if (obstacleChange === 1'b1) chgCount++;
        if (rxValid === 1'b1) begin
            rxCount++;
            if (expQ.size() == 0) check("rxExtra", 1, 0);
            else check("rxPacket", rxPacket, expQ.pop_front());
        end
    end
    initial begin
        repeat (60000) @(negedge clk);
        badCount++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        sensorSupplyOnReq = 1'b1;
        sensorSupplyOffReq = 1'b1;
        check("resetOut", {sendBusy, sensorSupply, obstacleLeft, rxValid, redLeds}, 0);
        @(negedge clk);
        sensorSupplyOnReq = 1'b0;
        sensorSupplyOffReq = 1'b0;
        @(negedge clk);
        check("supplyOn", sensorSupply, 1'b1);
        sensorSupplyOffReq = 1'b1;
        @(negedge clk);
        sensorSupplyOffReq = 1'b0;
        check("supplyOff", sensorSupply, 1'b0);
        motorRunReq = 1'b1;
        repeat (2) @(negedge clk);
        check("motorTry", motorEnable, 1'b1);
        repeat (START_CYC + 10) @(negedge clk);
        check("motorStop", motorEnable, 1'b0);
        sawOn = 1'b0;
        sawOff = 1'b0;
        repeat (4 * FLASH_CYC) begin
            @(negedge clk);
            sawOn |= (redLeds === 4'hF);
            sawOff |= (redLeds === 4'h0);
        end
        check("ledsFlash", {sawOn, sawOff}, 2'b11);
        motorRunReq = 1'b0;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        sensorSupplyOnReq = 1'b1;
        reflectLeft = 1'b1;
        for (int p = 0; p < 4; p++) begin
            emitterPower = irl_power_t'(p);
            repeat (300) @(negedge clk);
            check("level", emitterLevel, p[1:0]);
            if (p == 0) check("darkNoEcho", obstacleLeft, 1'b0);
        end
        waitFlags(2'b10);
        chgCount = 0;
        reflectRight = 1'b1;
        waitFlags(2'b11);
        reflectLeft = 1'b0;
        waitFlags(2'b01);
        reflectRight = 1'b0;
        waitFlags(2'b00);
        check("changeEvents", chgCount, 3);
        emitterPower = PWR_OFF;
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            pkt = irl_packet_t'(rnd[11:0]);
            if (k < 3) expQ.push_back(pkt);
            partner.sendBits({1'b1, k < 3, pkt.toggle, pkt.address, pkt.keyCode});
            repeat (1600) @(negedge clk);
        end
        check("rxCount", rxCount, 3);
        rnd = lfsr(rnd);
        sendAddress = {1'b1, 2'b00, rnd[4:0]};
        sendData = rnd[10:5];
        sendReq = 1'b1;
        @(negedge clk);
        sendReq = 1'b0;
        @(negedge clk);
        check("busyTaken", sendBusy, 1'b1);
        sendReq = 1'b1;
        @(negedge clk);
        sendReq = 1'b0;
        for (n = 0; n < 5000 && sendBusy === 1'b1; n++) @(negedge clk);
        check("busyLong", n >= 975, 1'b1);
        repeat (50) @(negedge clk);
        check("refusedSecond", sendBusy, 1'b0);
        check("queueEmpty", expQ.size(), 0);
        report_and_stop();
    end
endmodule
bind irl_link irl_link_assertions #(.START_CYC(START_CYC)) chk (.*);
`default_nettype wire
